// ### agen_core.sv
// Execution-unit end: issues address requests and register accesses, holds pointers
`timescale 1ns/1ps
module agen_core
  import agen_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  agen_if.core bus,
  input wire logic acc_req_in,
  input wire logic [1:0] acc_path_in,
  input wire logic [2:0] acc_mode_in,
  input wire logic [3:0] acc_ptr_in,
  input wire logic [15:0] acc_offset_in,
  input wire logic acc_byte_in,
  input wire logic ptr_load_in,
  input wire logic [15:0] ptr_load_val_in,
  input wire logic [2:0] cfg_addr_in,
  input wire logic [15:0] cfg_wdata_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  output logic [15:0] ea_out,
  output logic ea_valid_out,
  output logic [15:0] cfg_rdata_out,
  output logic hazard_out
);
  typedef struct packed {
    logic [15:0][15:0] ptrs;
    logic [15:0] ea;
    logic valid;
    logic [15:0] rdata;
    logic brev_wr;
    logic hazard;
    logic rd_pend;
    logic [3:0] idx;
  } state_s;
  state_s st_r;
  state_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.valid = bus.ack;
    st_nxt.rd_pend = cfg_rd_in;
    // Request index held through the answer, so a back-to-back request cannot steal the write-back
    if (acc_req_in) begin
      st_nxt.idx = acc_ptr_in;
    end
    st_nxt.brev_wr = cfg_wr_in && cfg_addr_in == REG_BREV_CTRL;
    // Flags an indirect read straight after a bit-reverse control write
    st_nxt.hazard = st_r.brev_wr && acc_req_in && acc_path_in != PATH_X_WRITE; // RQ15
    if (bus.ack) begin
      st_nxt.ea = bus.ea;
    end
    if (bus.ptr_we) begin
      st_nxt.ptrs[st_r.idx] = bus.ptr_new; // RQ5
    end
    if (ptr_load_in) begin
      st_nxt.ptrs[acc_ptr_in] = ptr_load_val_in;
    end
    if (st_r.rd_pend) begin
      st_nxt.rdata = bus.reg_rdata;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.req = acc_req_in;
  assign bus.path = acc_path_in;
  assign bus.mode = acc_mode_in;
  assign bus.ptr_idx = acc_ptr_in;
  assign bus.ptr_val = st_r.ptrs[acc_ptr_in];
  assign bus.offset = acc_offset_in;
  assign bus.byte_size = acc_byte_in;
  assign bus.reg_addr = cfg_addr_in;
  assign bus.reg_wdata = cfg_wdata_in;
  assign bus.reg_wr = cfg_wr_in;
  assign bus.reg_rd = cfg_rd_in;
  assign ea_out = st_r.ea;
  assign ea_valid_out = st_r.valid;
  assign cfg_rdata_out = st_r.rdata;
  assign hazard_out = st_r.hazard;
endmodule

// ### agen_device.sv
// Address correction block: modulo and bit-reversed effective addresses
//
// Overview of operation
// RQ1 - X select 15 disables X read/write modulo
// RQ2 - X modulo needs select not 15, enable
// RQ3 - Y modulo needs select not 15, enable
// RQ4 - Boundary test wraps addresses past bounds
// RQ5 - Pointer written back only pre/post modify
// RQ6 - Bit-reverse only on X writes
// RQ7 - Only the modifier is bit-order reversed
// RQ8 - Bit-reverse: select, enable, pre/post increment
// RQ9 - Byte data or other modes stay normal
// RQ10 - Reverse-carry add modifier, ignore mode offset
// RQ11 - Word data: clear LSB, modifier doubled
// RQ12 - Bit-reverse beats modulo on X write
// RQ13 - Software avoids modulo with bit-reverse together
// RQ14 - Bit-reverse buffer start aligned to size
// RQ15 - No indirect read right after control write
// RQ16 - Modifier is half the buffer in words
// RQ17 - Start and end held per space
// RQ18 - Y modulo assumes word data
// RQ19 - Enables clear after reset
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module agen_device
  import agen_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  agen_if.dev bus,
  output logic x_mod_active_out,
  output logic y_mod_active_out,
  output logic brev_active_out
);
  typedef struct packed {
    logic [15:0] mode_ctrl;
    logic [15:0] brev_ctrl;
    logic [15:0] x_start;
    logic [15:0] x_end;
    logic [15:0] y_start;
    logic [15:0] y_end;
    logic ack;
    logic [15:0] ea;
    logic [15:0] ptr_new;
    logic ptr_we;
    logic [15:0] rdata;
    logic x_mod;
    logic y_mod;
    logic brev;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic x_mod_en;
  logic y_mod_en;
  logic brev_en;
  logic modify;
  logic inc;
  logic up;
  logic brev_now;
  logic mod_now;
  logic [15:0] sum;
  logic [15:0] pre_ea;
  wire logic [15:0] rc_sum;
  wire logic [15:0] rc_carry;
  logic [15:0] rc_base;
  logic [15:0] bmod;
  logic [15:0] wrapped_ea;
  logic [15:0] wrapped_ptr;
  logic [15:0] ptr_post;
  logic [15:0] bound_lo;
  logic [15:0] bound_hi;
  logic [3:0] x_sel;
  logic [3:0] y_sel;
  logic [3:0] b_sel;

  assign x_sel = st_r.mode_ctrl[XSEL_LSB +: 4];
  assign y_sel = st_r.mode_ctrl[YSEL_LSB +: 4];
  assign b_sel = st_r.mode_ctrl[BSEL_LSB +: 4];
  // Select 15 parks a generator, so the stack pointer is never corrected by accident
  assign x_mod_en = x_sel != PTR_NONE && st_r.mode_ctrl[XMOD_EN_BIT]; // RQ1 RQ2
  assign y_mod_en = y_sel != PTR_NONE && st_r.mode_ctrl[YMOD_EN_BIT]; // RQ3
  assign brev_en = b_sel != PTR_NONE && st_r.brev_ctrl[BREV_EN_BIT]; // RQ8
  assign bound_lo = bus.path == PATH_Y ? st_r.y_start : st_r.x_start; // RQ17
  assign bound_hi = bus.path == PATH_Y ? st_r.y_end : st_r.x_end; // RQ17

  // Reverse-carry add: carry runs from the top bit downward, so only the modifier acts reversed
  assign rc_base = {bus.ptr_val[15:1], 1'b0}; // RQ7
  assign rc_carry[15] = 1'b0;
  for (genvar i = 0; i < 16; i++) begin : g_rev_carry
    assign rc_sum[i] = rc_base[i] ^ bmod[i] ^ rc_carry[i]; // RQ10
    if (i > 0) begin : g_carry
      assign rc_carry[i - 1] = (rc_base[i] & bmod[i]) | (rc_carry[i] & (rc_base[i] ^ bmod[i]));
    end
  end

  // The doubled modifier must fill the address exactly, and the selects must fit in it
  if (ADDR_W != 16 || BREV_MOD_MSB + 2 != ADDR_W || BSEL_LSB + 4 > ADDR_W) begin : g_width_check
    $error("address width does not match the control fields");
  end

  always_comb begin
    modify = bus.mode inside {AM_POST_INC, AM_POST_DEC, AM_PRE_INC, AM_PRE_DEC};
    inc = bus.mode inside {AM_POST_INC, AM_PRE_INC};
    up = !(bus.mode inside {AM_POST_DEC, AM_PRE_DEC});
    sum = 16'(bus.ptr_val + bus.offset);
    // Bit-reverse only on word X writes through the selected pointer
    brev_now = brev_en && bus.path == PATH_X_WRITE && inc && !bus.byte_size
      && bus.ptr_idx == b_sel; // RQ6 RQ8 RQ9
    // Bit-reverse wins on the X write path only; X reads keep modulo
    mod_now = ((bus.path == PATH_Y) ? (y_mod_en && bus.ptr_idx == y_sel)
      : (x_mod_en && bus.ptr_idx == x_sel)) && !brev_now; // RQ12
    bmod = {st_r.brev_ctrl[BREV_MOD_MSB:0], 1'b0}; // RQ11 RQ16
    case (bus.mode)
      AM_PRE_INC, AM_PRE_DEC, AM_REG_OFFSET, AM_LIT_OFFSET: pre_ea = sum;
      default: pre_ea = bus.ptr_val;
    endcase
    ptr_post = modify ? sum : bus.ptr_val;
  end

  modulo_wrap u_wrap_ea (
    .addr_in(pre_ea),
    .start_in(bound_lo),
    .end_in(bound_hi),
    .up_in(up),
    .word_in(bus.path == PATH_Y),
    .addr_out(wrapped_ea)
  ); // RQ18
  // Write-back is wrapped against the same bounds, so steps up to the buffer length keep the pointer in the buffer
  modulo_wrap u_wrap_ptr (
    .addr_in(ptr_post),
    .start_in(bound_lo),
    .end_in(bound_hi),
    .up_in(up),
    .word_in(bus.path == PATH_Y),
    .addr_out(wrapped_ptr)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = bus.req;
    st_nxt.ptr_we = 1'b0;
    st_nxt.rdata = 16'h0000;
    if (bus.req) begin
      if (brev_now) begin
        st_nxt.ea = bus.mode == AM_PRE_INC ? rc_sum : {bus.ptr_val[15:1], 1'b0}; // RQ11
        st_nxt.ptr_new = rc_sum; // RQ10
        st_nxt.ptr_we = 1'b1;
      end else if (mod_now) begin
        st_nxt.ea = wrapped_ea; // RQ4
        st_nxt.ptr_new = wrapped_ptr;
        st_nxt.ptr_we = modify; // RQ5
      end else begin
        st_nxt.ea = pre_ea;
        st_nxt.ptr_new = ptr_post;
        st_nxt.ptr_we = modify;
      end
    end
    if (bus.reg_wr) begin
      case (bus.reg_addr)
        REG_MODE_CTRL: st_nxt.mode_ctrl = bus.reg_wdata;
        REG_BREV_CTRL: st_nxt.brev_ctrl = bus.reg_wdata;
        REG_X_START: st_nxt.x_start = bus.reg_wdata;
        REG_X_END: st_nxt.x_end = bus.reg_wdata;
        REG_Y_START: st_nxt.y_start = bus.reg_wdata;
        REG_Y_END: st_nxt.y_end = bus.reg_wdata;
        default: ;
      endcase
    end
    // Status shows registered flags, one cycle behind a control write
    if (bus.reg_rd) begin
      case (bus.reg_addr)
        REG_MODE_CTRL: st_nxt.rdata = st_r.mode_ctrl;
        REG_BREV_CTRL: st_nxt.rdata = st_r.brev_ctrl;
        REG_X_START: st_nxt.rdata = st_r.x_start;
        REG_X_END: st_nxt.rdata = st_r.x_end;
        REG_Y_START: st_nxt.rdata = st_r.y_start;
        REG_Y_END: st_nxt.rdata = st_r.y_end;
        REG_STATUS: st_nxt.rdata = {13'h0, st_r.brev, st_r.y_mod, st_r.x_mod};
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
    // The X flag reports the write side, which loses modulo while bit-reverse is on
    st_nxt.x_mod = x_mod_en && !brev_en;
    st_nxt.y_mod = y_mod_en;
    st_nxt.brev = brev_en;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      // The X and Y selects reset to 15 and every enable clears, so no pointer is corrected until software asks
      st_r <= '0;
      st_r.mode_ctrl <= MODE_CTRL_RESET; // RQ19
      st_r.brev_ctrl <= BREV_CTRL_RESET; // RQ19
      st_r.x_start <= BOUND_RESET;
      st_r.x_end <= BOUND_RESET;
      st_r.y_start <= BOUND_RESET;
      st_r.y_end <= BOUND_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.ack = st_r.ack;
  assign bus.ea = st_r.ea;
  assign bus.ptr_new = st_r.ptr_new;
  assign bus.ptr_we = st_r.ptr_we;
  assign bus.reg_rdata = st_r.rdata;
  assign x_mod_active_out = st_r.x_mod;
  assign y_mod_active_out = st_r.y_mod;
  assign brev_active_out = st_r.brev;
endmodule

// ### agen_if.sv
// Link between the execution unit and the address correction block
`timescale 1ns/1ps
interface agen_if;
  import agen_pkg::*;
  logic req;
  logic [1:0] path;
  logic [2:0] mode;
  logic [3:0] ptr_idx;
  logic [15:0] ptr_val;
  logic [15:0] offset;
  logic byte_size;
  logic ack;
  logic [15:0] ea;
  logic [15:0] ptr_new;
  logic ptr_we;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  modport dev (input req, path, mode, ptr_idx, ptr_val, offset, byte_size, reg_addr, reg_wdata, reg_wr, reg_rd,
    output ack, ea, ptr_new, ptr_we, reg_rdata);
  modport core (output req, path, mode, ptr_idx, ptr_val, offset, byte_size, reg_addr, reg_wdata, reg_wr, reg_rd,
    input ack, ea, ptr_new, ptr_we, reg_rdata);
endinterface

// ### agen_pkg.sv
// Shared constants and types for the modulo and bit-reversed address generator
package agen_pkg;
  localparam int ADDR_W = 16;
  localparam logic [3:0] PTR_NONE = 4'hF;
  localparam int XSEL_LSB = 0;
  localparam int YSEL_LSB = 4;
  localparam int BSEL_LSB = 8;
  localparam int YMOD_EN_BIT = 14;
  localparam int XMOD_EN_BIT = 15;
  localparam int BREV_EN_BIT = 15;
  localparam int BREV_MOD_MSB = 14;
  localparam logic [15:0] MODE_CTRL_RESET = 16'h00FF;
  localparam logic [15:0] BREV_CTRL_RESET = 16'h0000;
  localparam logic [15:0] BOUND_RESET = 16'h0000;
  // Register indices on the software port
  localparam logic [2:0] REG_MODE_CTRL = 3'h0;
  localparam logic [2:0] REG_BREV_CTRL = 3'h1;
  localparam logic [2:0] REG_X_START = 3'h2;
  localparam logic [2:0] REG_X_END = 3'h3;
  localparam logic [2:0] REG_Y_START = 3'h4;
  localparam logic [2:0] REG_Y_END = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h6;
  typedef enum logic [2:0] {
    AM_INDIRECT, AM_POST_INC, AM_POST_DEC, AM_PRE_INC, AM_PRE_DEC, AM_REG_OFFSET, AM_LIT_OFFSET
  } addr_mode_e;
  typedef enum logic [1:0] {PATH_X_READ, PATH_X_WRITE, PATH_Y} agen_path_e;
endpackage

// ### agen_props.sv
// Link checks between the execution unit end and the address correction end
`timescale 1ns/1ps
module agen_props
  import agen_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic req,
  input wire logic [1:0] path,
  input wire logic [2:0] mode,
  input wire logic [15:0] ptr_val,
  input wire logic ack,
  input wire logic [15:0] ea,
  input wire logic [15:0] ptr_new,
  input wire logic ptr_we,
  input wire logic [2:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_ack_follows_req: assert property (req |=> ack) else $error("no ack after request");
  a_ack_only_req: assert property (!req |=> !ack) else $error("ack without request");
  a_offset_no_wb: assert property (req && mode inside {AM_REG_OFFSET, AM_LIT_OFFSET} |=> !ptr_we)
    else $error("offset mode wrote pointer back");
  a_modify_wb: assert property (req && mode inside {AM_POST_INC, AM_POST_DEC, AM_PRE_INC, AM_PRE_DEC} |=> ptr_we)
    else $error("modify mode lost write back");
  a_read_ea_ptr: assert property (req && path == PATH_X_READ && mode inside {AM_INDIRECT, AM_POST_INC}
    |=> ea == $past(ptr_val)) else $error("address not the pointer");
  a_pre_ea_new: assert property (req && path != PATH_Y && mode inside {AM_PRE_INC, AM_PRE_DEC} |=> ea == ptr_new)
    else $error("pre modify address differs from new pointer");
  a_ea_stands: assert property (!req |=> $stable(ea)) else $error("address moved without request");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  // Reset must silence the link, so this check overrides the default disable that would mask it
  a_reset_quiet: assert property (disable iff (1'b0) rst_in |=> !ack && !ptr_we)
    else $error("activity during reset");
endmodule

// ### modulo_wrap.sv
// Circular buffer boundary correction for one address
`timescale 1ns/1ps
module modulo_wrap
  import agen_pkg::*;
(
  input wire logic [15:0] addr_in,
  input wire logic [15:0] start_in,
  input wire logic [15:0] end_in,
  input wire logic up_in,
  input wire logic word_in,
  output logic [15:0] addr_out
);
  logic [15:0] len;
  logic [15:0] fixed;
  always_comb begin
    len = 16'(end_in - start_in + 16'h0001);
    fixed = addr_in;
    // Compare past the bound, not equality, so big steps still wrap
    if (up_in && addr_in > end_in) begin
      fixed = 16'(addr_in - len); // RQ4
    end else if (!up_in && addr_in < start_in) begin
      fixed = 16'(addr_in + len); // RQ4
    end
    addr_out = word_in ? {fixed[15:1], 1'b0} : fixed;
  end
endmodule

// ### tb.sv
// Self-checking bench for both ends of the address correction link
`timescale 1ns/1ps
module tb;
  import agen_pkg::*;
  logic core_clk_in, rst_in, acc_req_in, acc_byte_in, ptr_load_in, cfg_wr_in, cfg_rd_in, ea_valid_out, hazard_out;
  logic x_mod_active_out, y_mod_active_out, brev_active_out;
  logic [1:0] acc_path_in;
  logic [2:0] acc_mode_in, cfg_addr_in;
  logic [3:0] acc_ptr_in;
  logic [15:0] acc_offset_in, ptr_load_val_in, cfg_wdata_in, ea_out, cfg_rdata_out, e;
  int miscompares = 0;
  int cmp_count = 0;
  agen_if agen_if_i ();
  agen_device agen_device_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .bus(agen_if_i.dev),
    .x_mod_active_out(x_mod_active_out), .y_mod_active_out(y_mod_active_out), .brev_active_out(brev_active_out));
  agen_core agen_core_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .bus(agen_if_i.core), .acc_req_in(acc_req_in),
    .acc_path_in(acc_path_in), .acc_mode_in(acc_mode_in), .acc_ptr_in(acc_ptr_in), .acc_offset_in(acc_offset_in),
    .acc_byte_in(acc_byte_in), .ptr_load_in(ptr_load_in), .ptr_load_val_in(ptr_load_val_in),
    .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in), .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
    .ea_out(ea_out), .ea_valid_out(ea_valid_out), .cfg_rdata_out(cfg_rdata_out), .hazard_out(hazard_out));
  agen_props agen_props_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .req(agen_if_i.req), .path(agen_if_i.path),
    .mode(agen_if_i.mode), .ptr_val(agen_if_i.ptr_val), .ack(agen_if_i.ack), .ea(agen_if_i.ea),
    .ptr_new(agen_if_i.ptr_new), .ptr_we(agen_if_i.ptr_we), .reg_addr(agen_if_i.reg_addr),
    .reg_rd(agen_if_i.reg_rd), .reg_rdata(agen_if_i.reg_rdata));
  function automatic logic [15:0] rv(input logic [15:0] x);
    for (int i = 0; i < 16; i++) rv[i] = x[15 - i];
  endfunction
  function automatic logic [15:0] lin(input logic [2:0] m, input logic [15:0] p, input logic [15:0] o);
    return (m == AM_INDIRECT || m == AM_POST_INC || m == AM_POST_DEC) ? p : p + o;
  endfunction
  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    cmp_count++;
    if (g !== x) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= a;
    cfg_wdata_in <= d;
    @(posedge core_clk_in);
    cfg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] x);
    @(posedge core_clk_in);
    cfg_rd_in <= 1'b1;
    cfg_addr_in <= a;
    @(posedge core_clk_in);
    cfg_rd_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    chk(cfg_rdata_out, x);
  endtask
  // Waits for the answer, then lets the pointer write back land before returning
  task automatic go(input logic [1:0] p, input logic [2:0] m, input logic [3:0] n, input logic [15:0] o, input logic b);
    @(posedge core_clk_in);
    acc_req_in <= 1'b1;
    acc_path_in <= p;
    acc_mode_in <= m;
    acc_ptr_in <= n;
    acc_offset_in <= o;
    acc_byte_in <= b;
    @(posedge core_clk_in);
    acc_req_in <= 1'b0;
    for (int k = 0; k < 8 && ea_valid_out !== 1'b1; k++) begin
      @(posedge core_clk_in);
      #1;
    end
    chk({15'h0000, ea_valid_out}, 16'h0001);
    repeat (3) @(posedge core_clk_in);
  endtask
  task automatic t(input logic [1:0] p, input logic [2:0] m, input logic [3:0] n, input logic [15:0] v,
    input logic [15:0] o, input logic b, input logic [15:0] x);
    @(posedge core_clk_in);
    ptr_load_in <= 1'b1;
    acc_ptr_in <= n;
    ptr_load_val_in <= v;
    @(posedge core_clk_in);
    ptr_load_in <= 1'b0;
    go(p, m, n, o, b);
    chk(ea_out, x);
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
  initial begin
    {acc_req_in, acc_byte_in, ptr_load_in, cfg_wr_in, cfg_rd_in, acc_path_in, acc_mode_in, cfg_addr_in} = '0;
    {acc_ptr_in, acc_offset_in, ptr_load_val_in, cfg_wdata_in} = '0;
    rst_in = 1'b1;
    void'($urandom(32'h321c9482));
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[2:0], a == 0 ? MODE_CTRL_RESET : 16'h0000);
    wr(3'h7, 16'hA5A5);
    rd(3'h7, 16'h0000);
    chk({13'h0, brev_active_out, y_mod_active_out, x_mod_active_out}, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      logic [2:0] m;
      logic [15:0] v, o;
      m = 3'($urandom_range(0, 6));
      v = 16'($urandom);
      o = 16'($urandom);
      t(2'($urandom_range(0, 2)), m, 4'($urandom_range(0, 14)), v, o, 1'($urandom), lin(m, v, o));
    end
    $display("test linear done");
    wr(REG_X_START, 16'h1000);
    wr(REG_X_END, 16'h100F);
    wr(REG_MODE_CTRL, 16'h8FF2);
    rd(REG_STATUS, 16'h0001);
    chk({13'h0, brev_active_out, y_mod_active_out, x_mod_active_out}, 16'h0001);
    t(PATH_X_READ, AM_PRE_INC, 4'h2, 16'h100E, 16'h0004, 1'b0, 16'h1002);
    go(PATH_X_READ, AM_INDIRECT, 4'h2, 16'h0000, 1'b0);
    chk(ea_out, 16'h1002);
    t(PATH_X_READ, AM_REG_OFFSET, 4'h2, 16'h100E, 16'h0004, 1'b0, 16'h1002);
    go(PATH_X_READ, AM_INDIRECT, 4'h2, 16'h0000, 1'b0);
    chk(ea_out, 16'h100E);
    t(PATH_X_WRITE, AM_PRE_DEC, 4'h2, 16'h1001, 16'hFFFC, 1'b0, 16'h100D);
    t(PATH_X_READ, AM_PRE_INC, 4'h3, 16'h100E, 16'h0004, 1'b0, 16'h1012);
    wr(REG_MODE_CTRL, 16'h0FF2);
    t(PATH_X_READ, AM_PRE_INC, 4'h2, 16'h100E, 16'h0004, 1'b0, 16'h1012);
    wr(REG_MODE_CTRL, 16'h8FFF);
    t(PATH_X_WRITE, AM_PRE_INC, 4'hF, 16'h100E, 16'h0004, 1'b0, 16'h1012);
    wr(REG_Y_START, 16'h2000);
    wr(REG_Y_END, 16'h201F);
    wr(REG_MODE_CTRL, 16'h4F3F);
    t(PATH_Y, AM_PRE_INC, 4'h3, 16'h201E, 16'h0002, 1'b0, 16'h2000);
    t(PATH_Y, AM_PRE_INC, 4'h3, 16'h2011, 16'h0002, 1'b0, 16'h2012);
    t(PATH_X_READ, AM_PRE_INC, 4'h3, 16'h201E, 16'h0002, 1'b0, 16'h2020);
    chk({13'h0, brev_active_out, y_mod_active_out, x_mod_active_out}, 16'h0002);
    $display("test modulo done");
    wr(REG_BREV_CTRL, 16'h8008);
    wr(REG_MODE_CTRL, 16'h05FF);
    rd(REG_STATUS, 16'h0004);
    chk({13'h0, brev_active_out, y_mod_active_out, x_mod_active_out}, 16'h0004);
    e = 16'h0000;
    t(PATH_X_WRITE, AM_POST_INC, 4'h5, 16'h0001, 16'h0002, 1'b0, e);
    for (int i = 0; i < 8; i++) begin
      e = rv(rv(e) + rv(16'h0010));
      go(PATH_X_WRITE, AM_POST_INC, 4'h5, 16'h0002, 1'b0);
      chk(ea_out, e);
    end
    t(PATH_X_WRITE, AM_PRE_INC, 4'h5, 16'h0000, 16'h0002, 1'b0, 16'h0010);
    t(PATH_X_WRITE, AM_PRE_INC, 4'h5, 16'h0004, 16'h0002, 1'b1, 16'h0006);
    t(PATH_X_WRITE, AM_PRE_DEC, 4'h5, 16'h0004, 16'hFFFE, 1'b0, 16'h0002);
    t(PATH_X_READ, AM_PRE_INC, 4'h5, 16'h0004, 16'h0002, 1'b0, 16'h0006);
    wr(REG_MODE_CTRL, 16'h85F5);
    t(PATH_X_WRITE, AM_PRE_INC, 4'h5, 16'h1000, 16'h0002, 1'b0, 16'h1010);
    t(PATH_X_READ, AM_PRE_INC, 4'h5, 16'h100E, 16'h0004, 1'b0, 16'h1002);
    chk({13'h0, brev_active_out, y_mod_active_out, x_mod_active_out}, 16'h0004);
    // A read through the bit-reverse pointer right after a control write must be flagged
    @(posedge core_clk_in);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= REG_BREV_CTRL;
    cfg_wdata_in <= 16'h8008;
    @(posedge core_clk_in);
    cfg_wr_in <= 1'b0;
    acc_req_in <= 1'b1;
    acc_path_in <= PATH_X_READ;
    acc_mode_in <= AM_INDIRECT;
    acc_ptr_in <= 4'h5;
    @(posedge core_clk_in);
    acc_req_in <= 1'b0;
    #1;
    chk({15'h0, hazard_out}, 16'h0001);
    t(PATH_X_READ, AM_INDIRECT, 4'h5, 16'h1004, 16'h0000, 1'b0, 16'h1004);
    chk({15'h0, hazard_out}, 16'h0000);
    $display("test bit reverse done");
    conclude();
  end
endmodule
